/* File: pinsel_params.svh */
/*
 * Constants for the multi-function pin selector: register offsets,
 * field positions, reset values and function codes.
 * Assumes inclusion by the pin mux, the top module, the checker and the bench.
 */
`ifndef PINSEL_PARAMS_SVH
`define PINSEL_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_PIN_FUNCTION_SELECT 8'h0B
`define OFS_IRQ_STATUS 8'h40
`define OFS_IRQ_MASK 8'h41
`define OFS_OP_CONTROL 8'h42
`define OFS_PIN_STATE 8'h43

// ****************************************
// Field positions and reset values
// ****************************************
`define FLD_PIN1_HI 12
`define FLD_PIN1_LO 8
`define FLD_PIN0_HI 4
`define FLD_PIN0_LO 0
`define RST_PIN_FUNCTION_SELECT 16'h0000
`define RST_IRQ_MASK 4'h0
`define IRQ_BIT_SLOT_A 0
`define IRQ_BIT_SLOT_B 1
`define IRQ_BIT_SAMPLE 2
`define IRQ_BIT_RUN 3

// ****************************************
// Function codes
// ****************************************
`define FN_INTERRUPT 5'h01
`define FN_SAMPLE_TIMING 5'h02
`define FN_LED_A 5'h05
`define FN_LED_B 5'h06
`define FN_LED_AB 5'h07
`define FN_WRITTEN_A 5'h0C
`define FN_WRITTEN_B 5'h0D
`define FN_WRITTEN_AB 5'h0E
`define FN_HALF_RATE 5'h0F
`define FN_LOGIC_0 5'h10
`define FN_LOGIC_1 5'h11
`define FN_OSC_COPY 5'h13

`endif

/* File: pinsel_pkg.sv */
/*
 * Types shared by the pin selector modules.
 * Assumes nothing of its surroundings.
 */
package pinsel_pkg;
    typedef logic [4:0] func_code_type;
    typedef logic [7:0] reg_addr_type;
    typedef logic [15:0] reg_data_type;
    typedef enum logic [1:0] {RUN_STANDBY, RUN_ACTIVE} run_state_type;
endpackage

/* File: pin_src_if.sv */
/*
 * Bundle of timing sources fed to each pin multiplexer.
 * Assumes all members are synchronous to the core clock.
 */
`timescale 1ns/1ps
interface pin_src_if;
    logic irq;
    logic sample_active;
    logic led_a;
    logic led_b;
    logic written_a;
    logic written_b;
    logic half_rate;
    logic osc_copy;
    modport source (output irq, sample_active, led_a, led_b, written_a, written_b,
        half_rate, osc_copy);
    modport sink (input irq, sample_active, led_a, led_b, written_a, written_b,
        half_rate, osc_copy);
endinterface

/* File: pin_func_mux.sv */
/*
 * One multi-function pin: decodes a 5-bit code to a source.
 * Assumes sources and code are synchronous; output is combinational.
 */
`timescale 1ns/1ps
`include "pinsel_params.svh"
module pin_func_mux
    import pinsel_pkg::*;
(
    pin_src_if.sink src, // Shared timing sources
    input wire pinsel_pkg::func_code_type code, // Function code of this pin
    output logic pin_val // Selected level
);
    always_comb begin
        case (code)
            `FN_INTERRUPT: pin_val = src.irq;
            `FN_SAMPLE_TIMING: pin_val = src.sample_active;
            `FN_LED_A: pin_val = src.led_a;
            `FN_LED_B: pin_val = src.led_b;
            `FN_LED_AB: pin_val = src.led_a | src.led_b;
            `FN_WRITTEN_A: pin_val = src.written_a;
            `FN_WRITTEN_B: pin_val = src.written_b;
            `FN_WRITTEN_AB: pin_val = src.written_a | src.written_b;
            `FN_HALF_RATE: pin_val = src.half_rate;
            `FN_LOGIC_0: pin_val = 1'b0;
            `FN_LOGIC_1: pin_val = 1'b1;
            `FN_OSC_COPY: pin_val = src.osc_copy;
            default: pin_val = 1'b0;
        endcase
    end
endmodule

/* File: pin_timing_select.sv */
/*
 * Multi-function pin selector with register port and interrupt.
 * Assumes slot/sample/LED/oscillator events arrive as core-clock
 * synchronous inputs from the timing core; pins register the choice.
 */
// The implementer's own choice: strobed register access.
//
// Operation
// - Two pins, codes in bits 12:8, 4:0
// - Code 0C shows slot A result written
// - Code 0D shows slot B result written
// - Code 0E shows either slot written
// - Written flag set at slot end, cleared next sample
// - Code 0F toggles once per sample
// - Toggle starts low leaving standby
// - Code 10 drives constant low
// - Code 11 drives constant high
// - Code 13 copies 32 kHz oscillator
// - Code 01 copies device interrupt DEV_IRQ
// - Code 02 spans first to last slot
// - Codes 05-07 copy LED pulses A, B, both
`timescale 1ns/1ps
`include "pinsel_params.svh"
module pin_timing_select
    import pinsel_pkg::*;
(
    input wire logic CORE_CLK, // 100 MHz core clock
    input wire logic RSTN, // Asynchronous reset, active low
    input wire pinsel_pkg::reg_addr_type ADDR, // Register address
    input wire pinsel_pkg::reg_data_type WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    output pinsel_pkg::reg_data_type RDATA, // Read data, cycle after RD
    input wire logic SAMPLE_START, // Pulse: sample begins
    input wire logic SLOT_A_DONE, // Pulse: slot A data stored
    input wire logic SLOT_B_DONE, // Pulse: slot B data stored
    input wire logic SAMPLE_DONE, // Pulse: last enabled slot ends
    input wire logic LED_A_PULSE, // Slot A LED drive level
    input wire logic LED_B_PULSE, // Slot B LED drive level
    input wire logic OSC_32K, // Low-frequency oscillator level
    input wire logic DEV_IRQ, // Device interrupt from its own logic
    output logic MULTI_FUNCTION_PIN_ZERO, // Pin zero level
    output logic MULTI_FUNCTION_PIN_ONE, // Pin one level
    output logic IRQ // Block interrupt, level
);
    import pinsel_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    reg_data_type sel_r;
    logic [3:0] stat_r;
    logic [3:0] mask_r;
    logic run_req_r;
    run_state_type run_r;
    logic written_a_r;
    logic written_b_r;
    logic sample_active_r;
    logic half_rate_r;
    reg_data_type rdata_r;
    logic pin0_r;
    logic pin1_r;
    logic irq_r;

    pin_src_if src();
    logic pin0_nxt;
    logic pin1_nxt;

    // ****************************************
    // Register decode
    // ****************************************
    wire wr_sel = WR && (ADDR == `OFS_PIN_FUNCTION_SELECT);
    wire wr_mask = WR && (ADDR == `OFS_IRQ_MASK);
    wire wr_ctl = WR && (ADDR == `OFS_OP_CONTROL);
    wire rd_stat = RD && (ADDR == `OFS_IRQ_STATUS);
    wire running = (run_r == RUN_ACTIVE);
    wire [3:0] stat_evt = {run_req_r & ~running, SAMPLE_DONE & running,
        SLOT_B_DONE & running, SLOT_A_DONE & running};
    wire [3:0] stat_nxt = (rd_stat ? 4'h0 : stat_r) | stat_evt;
    wire func_code_type code0 = sel_r[`FLD_PIN0_HI:`FLD_PIN0_LO];
    wire func_code_type code1 = sel_r[`FLD_PIN1_HI:`FLD_PIN1_LO];
    reg_data_type rdata_nxt;

    always_comb begin
        case (ADDR)
            `OFS_PIN_FUNCTION_SELECT: rdata_nxt = sel_r & 16'h1F1F;
            `OFS_IRQ_STATUS: rdata_nxt = {12'h000, stat_r};
            `OFS_IRQ_MASK: rdata_nxt = {12'h000, mask_r};
            `OFS_OP_CONTROL: rdata_nxt = {14'h0, running, run_req_r};
            `OFS_PIN_STATE: rdata_nxt = {14'h0, pin1_r, pin0_r};
            default: rdata_nxt = 16'h0000;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sel_r <= `RST_PIN_FUNCTION_SELECT;
            mask_r <= `RST_IRQ_MASK;
            run_req_r <= 1'b0;
            stat_r <= 4'h0;
            rdata_r <= 16'h0000;
        end else begin
            if (wr_sel) begin
                sel_r <= WDATA & 16'h1F1F;
            end
            if (wr_mask) begin
                mask_r <= WDATA[3:0];
            end
            if (wr_ctl) begin
                run_req_r <= WDATA[0];
            end
            stat_r <= stat_nxt;
            rdata_r <= RD ? rdata_nxt : 16'h0000;
        end
    end

    // ****************************************
    // Sample timing
    // ****************************************
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            run_r <= RUN_STANDBY;
        end else begin
            case (run_r)
                RUN_STANDBY: run_r <= run_req_r ? RUN_ACTIVE : RUN_STANDBY;
                RUN_ACTIVE: run_r <= run_req_r ? RUN_ACTIVE : RUN_STANDBY;
                default: run_r <= RUN_STANDBY;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            written_a_r <= 1'b0;
            written_b_r <= 1'b0;
            sample_active_r <= 1'b0;
            half_rate_r <= 1'b0;
        end else if (!running) begin
            written_a_r <= 1'b0;
            written_b_r <= 1'b0;
            sample_active_r <= 1'b0;
            half_rate_r <= 1'b0;
        end else begin
            if (SLOT_A_DONE) begin
                written_a_r <= 1'b1;
            end else if (SAMPLE_START) begin
                written_a_r <= 1'b0;
            end
            if (SLOT_B_DONE) begin
                written_b_r <= 1'b1;
            end else if (SAMPLE_START) begin
                written_b_r <= 1'b0;
            end
            if (SAMPLE_START) begin
                sample_active_r <= 1'b1;
            end else if (SAMPLE_DONE) begin
                sample_active_r <= 1'b0;
            end
            if (SAMPLE_DONE) begin
                half_rate_r <= ~half_rate_r;
            end
        end
    end

    // ****************************************
    // Pin selection
    // ****************************************
    assign src.irq = DEV_IRQ;
    assign src.sample_active = sample_active_r;
    assign src.led_a = LED_A_PULSE;
    assign src.led_b = LED_B_PULSE;
    assign src.written_a = written_a_r;
    assign src.written_b = written_b_r;
    assign src.half_rate = half_rate_r;
    assign src.osc_copy = OSC_32K;

    pin_func_mux mux0 (
        .src(src),
        .code(code0),
        .pin_val(pin0_nxt)
    );

    pin_func_mux mux1 (
        .src(src),
        .code(code1),
        .pin_val(pin1_nxt)
    );

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pin0_r <= 1'b0;
            pin1_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            pin0_r <= pin0_nxt;
            pin1_r <= pin1_nxt;
            irq_r <= |(stat_nxt & mask_r);
        end
    end

    assign RDATA = rdata_r;
    assign MULTI_FUNCTION_PIN_ZERO = pin0_r;
    assign MULTI_FUNCTION_PIN_ONE = pin1_r;
    assign IRQ = irq_r;
endmodule

/* File: pin_timing_select_assertions.sv */
/*
 * Checker for the pin selector: pin levels against codes and sources.
 * Assumes binding to pin_timing_select; tracks codes and run from writes.
 */
`timescale 1ns/1ps
`include "pinsel_params.svh"
module pin_timing_select_assertions
    import pinsel_pkg::*;
(
    input wire logic CORE_CLK, // Clock
    input wire logic RSTN, // Reset
    input wire pinsel_pkg::reg_addr_type ADDR, // Address
    input wire pinsel_pkg::reg_data_type WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic SLOT_A_DONE, // Slot A stored
    input wire logic SAMPLE_DONE, // Sample end
    input wire logic LED_A_PULSE, // LED A
    input wire logic LED_B_PULSE, // LED B
    input wire logic OSC_32K, // Oscillator
    input wire logic DEV_IRQ, // Device interrupt
    input wire logic MULTI_FUNCTION_PIN_ZERO, // Pin zero
    input wire logic MULTI_FUNCTION_PIN_ONE // Pin one
);
    // ****************************************
    // Code and run tracking
    // ****************************************
    func_code_type c0_r;
    func_code_type c1_r;
    logic run_r;
    logic run_q;
    wire p0 = MULTI_FUNCTION_PIN_ZERO;
    wire p1 = MULTI_FUNCTION_PIN_ONE;
    wire sel_wr = WR && ADDR == `OFS_PIN_FUNCTION_SELECT;
    wire run_wr = WR && ADDR == `OFS_OP_CONTROL;
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            c0_r <= '0;
            c1_r <= '0;
            run_r <= 1'b0;
            run_q <= 1'b0;
        end else begin
            c0_r <= sel_wr ? WDATA[4:0] : c0_r;
            c1_r <= sel_wr ? WDATA[12:8] : c1_r;
            run_r <= run_wr ? WDATA[0] : run_r;
            run_q <= run_r;
        end
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    property p_low; c0_r == `FN_LOGIC_0 |=> !p0; endproperty
    a_low: assert property (p_low) else $error("pin0 not low");
    property p_high; c1_r == `FN_LOGIC_1 |=> p1; endproperty
    a_high: assert property (p_high) else $error("pin1 not high");
    property p_osc; c0_r == `FN_OSC_COPY |=> p0 == $past(OSC_32K); endproperty
    a_osc: assert property (p_osc) else $error("osc copy");
    property p_irq; c1_r == `FN_INTERRUPT |=> p1 == $past(DEV_IRQ); endproperty
    a_irq: assert property (p_irq) else $error("irq copy");
    property p_led; c0_r == `FN_LED_AB |=> p0 == $past(LED_A_PULSE | LED_B_PULSE); endproperty
    a_led: assert property (p_led) else $error("led copy");
    property p_undef; c0_r == 5'h1F |=> !p0; endproperty
    a_undef: assert property (p_undef) else $error("undefined code");
    property p_wr_a; c0_r == `FN_WRITTEN_A && run_q && SLOT_A_DONE ##1
        c0_r == `FN_WRITTEN_A |=> p0; endproperty
    a_wr_a: assert property (p_wr_a) else $error("written flag");
    property p_tog; c1_r == `FN_HALF_RATE && run_q && SAMPLE_DONE ##1
        c1_r == `FN_HALF_RATE |=> p1 != $past(p1); endproperty
    a_tog: assert property (p_tog) else $error("half rate");
    property p_stby; !run_r && !run_q && c1_r == `FN_HALF_RATE ##1
        !run_q && c1_r == `FN_HALF_RATE |=> !p1; endproperty
    a_stby: assert property (p_stby) else $error("half rate idle");
endmodule
bind pin_timing_select pin_timing_select_assertions chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .SLOT_A_DONE(SLOT_A_DONE),
    .SAMPLE_DONE(SAMPLE_DONE), .LED_A_PULSE(LED_A_PULSE), .LED_B_PULSE(LED_B_PULSE),
    .OSC_32K(OSC_32K), .DEV_IRQ(DEV_IRQ), .MULTI_FUNCTION_PIN_ZERO(MULTI_FUNCTION_PIN_ZERO),
    .MULTI_FUNCTION_PIN_ONE(MULTI_FUNCTION_PIN_ONE));

/* File: pin_peripheral_model.sv */
/*
 * Peripheral triggered by a pin: counts rising edges.
 * Assumes the pin is synchronous to the core clock.
 */
`timescale 1ns/1ps
module pin_peripheral_model (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic trig, // Trigger pin
    output int edges // Rising edges seen
);
    logic last_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_r <= 1'b0;
            edges <= 0;
        end else begin
            last_r <= trig;
            edges <= (trig && !last_r) ? edges + 1 : edges;
        end
    end
endmodule

/* File: pin_timing_select_test.sv */
/*
 * Self-checking bench for the pin selector.
 * Assumes the design, checker and peripheral model are compiled first.
 */
`timescale 1ns/1ps
`include "pinsel_params.svh"
module pin_timing_select_test;
    import pinsel_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    reg_addr_type addr = '0;
    reg_data_type wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] ev = '0; // Slot A, slot B, start, sample done
    logic [3:0] src = '0; // Osc, irq, LED A, LED B
    reg_data_type rdata;
    logic pin0;
    logic pin1;
    logic irq;
    int edges;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    pin_timing_select DUT (.CORE_CLK(clk), .RSTN(rst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .SAMPLE_START(ev[2]), .SLOT_A_DONE(ev[0]),
        .SLOT_B_DONE(ev[1]), .SAMPLE_DONE(ev[3]), .LED_A_PULSE(src[2]),
        .LED_B_PULSE(src[3]), .OSC_32K(src[0]), .DEV_IRQ(src[1]),
        .MULTI_FUNCTION_PIN_ZERO(pin0), .MULTI_FUNCTION_PIN_ONE(pin1), .IRQ(irq));
    pin_peripheral_model peer (.clk(clk), .rst_n(rst_n), .trig(pin0), .edges(edges));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic close_out();
        $display("checked=%0d failed=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_pin(input logic g, input logic e);
        chk({15'h0, g}, {15'h0, e});
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input reg_addr_type a, input reg_data_type d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input reg_addr_type a, input reg_data_type e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        rd_reg(`OFS_PIN_FUNCTION_SELECT, 16'h0000);
        rd_reg(8'h55, 16'h0000);
        wr_reg(`OFS_PIN_FUNCTION_SELECT, 16'hFFFF);
        rd_reg(`OFS_PIN_FUNCTION_SELECT, 16'h1F1F);
        settle(1);
        chk(rdata, 16'h0000);
    endtask
    task automatic t_const();
        wr_reg(`OFS_PIN_FUNCTION_SELECT, 16'h1110);
        settle(2);
        chk_pin(pin0, 1'b0);
        chk_pin(pin1, 1'b1);
        @(posedge clk);
        src <= 4'hF;
        foreach (ev[i]) begin
            wr_reg(`OFS_PIN_FUNCTION_SELECT, {11'h0, 5'h1F - 5'(i * 3)});
            settle(2);
            chk_pin(pin0, 1'b0);
        end
    endtask
    task automatic t_copy();
        for (int j = 0; j < 2; j++) begin
            wr_reg(`OFS_PIN_FUNCTION_SELECT, (j == 1) ? 16'h0007 : 16'h0113);
            for (int i = 0; i < 4; i++) begin
                @(posedge clk);
                src <= {i[1], i[0], i[1], i[0]};
                settle(2);
                chk_pin(pin0, (j == 1) ? |i[1:0] : i[0]);
                chk_pin(pin1, (j == 1) ? 1'b0 : i[1]);
            end
        end
    endtask
    task automatic t_run();
        int e0;
        e0 = edges;
        wr_reg(`OFS_PIN_FUNCTION_SELECT, 16'h0F0C);
        wr_reg(`OFS_IRQ_MASK, 16'h0001);
        wr_reg(`OFS_OP_CONTROL, 16'h0001);
        settle(2);
        chk_pin(pin1, 1'b0);
        rd_reg(`OFS_IRQ_STATUS, 16'h0008);
        pulse(1);
        settle(1);
        chk_pin(irq, 1'b0);
        rd_reg(`OFS_IRQ_STATUS, 16'h0002);
        pulse(0);
        settle(1);
        chk_pin(pin0, 1'b1);
        chk_pin(irq, 1'b1);
        rd_reg(`OFS_IRQ_STATUS, 16'h0001);
        settle(1);
        chk_pin(irq, 1'b0);
        pulse(2);
        settle(1);
        chk_pin(pin0, 1'b0);
        pulse(3);
        settle(1);
        chk_pin(pin1, 1'b1);
        pulse(3);
        settle(1);
        chk_pin(pin1, 1'b0);
        chk(16'(edges - e0), 16'h0001);
    endtask
    task automatic t_more();
        wr_reg(`OFS_PIN_FUNCTION_SELECT, 16'h020E);
        pulse(2);
        settle(1);
        chk_pin(pin1, 1'b1);
        chk_pin(pin0, 1'b0);
        pulse(1);
        settle(1);
        chk_pin(pin0, 1'b1);
        pulse(3);
        settle(1);
        chk_pin(pin1, 1'b0);
        wr_reg(`OFS_PIN_FUNCTION_SELECT, 16'h0D0D);
        settle(2);
        chk_pin(pin1, 1'b1);
        pulse(2);
        settle(1);
        chk_pin(pin1, 1'b0);
        wr_reg(`OFS_PIN_FUNCTION_SELECT, 16'h0506);
        src <= 4'b0100;
        settle(2);
        chk_pin(pin1, 1'b1);
        chk_pin(pin0, 1'b0);
    endtask
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_const();
        t_copy();
        t_run();
        t_more();
        close_out();
    end
endmodule
